// file: rtl/rstgen_pkg.sv
package rstgen_pkg;
   // Requester count and bit positions in the request vector
   localparam int unsigned NUM_REQ       = 6;
   localparam int unsigned REQ_SW_UNIT   = 0;
   localparam int unsigned REQ_SW_CPU    = 1;
   localparam int unsigned REQ_HOST_CMD  = 2;
   localparam int unsigned REQ_WATCHDOG  = 3;
   localparam int unsigned REQ_POWER_ON  = 4;
   localparam int unsigned REQ_EXT_PIN   = 5;

   // Stretch after the last requester drops, in clock cycles
   localparam int unsigned STRETCH_CYCLES = 1;
   localparam logic [1:0]  STRETCH_LOAD   = 2'(STRETCH_CYCLES);

   // Pin input synchroniser depth
   localparam int unsigned SYNC_STAGES = 3;

   // Processor start address after release
   localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;

   // Wake cause encodings
   localparam int unsigned CAUSE_W = 5;
   localparam logic [4:0] CAUSE_POWER_ON       = 5'h00;
   localparam logic [4:0] CAUSE_RF_LEVEL       = 5'h01;
   localparam logic [4:0] CAUSE_WAKE_TIMER     = 5'h02;
   localparam logic [4:0] CAUSE_CONTACT_AUX    = 5'h03;
   localparam logic [4:0] CAUSE_CARD_PRESENCE  = 5'h04;
   localparam logic [4:0] CAUSE_I2C_MATCH      = 5'h05;
   localparam logic [4:0] CAUSE_RESERVED       = 5'h06;
   localparam logic [4:0] CAUSE_SPI            = 5'h07;
   localparam logic [4:0] CAUSE_USB_RESUME     = 5'h08;
   localparam logic [4:0] CAUSE_SOFT_RESET     = 5'h09;
   localparam logic [4:0] CAUSE_WATCHDOG       = 5'h0a;
   localparam logic [4:0] CAUSE_TX_SUPPLY      = 5'h0b;
   localparam logic [4:0] CAUSE_HOST_RESET     = 5'h0c;
   localparam logic [4:0] CAUSE_THERMAL_A      = 5'h0d;
   localparam logic [4:0] CAUSE_THERMAL_B      = 5'h0e;
   localparam logic [4:0] CAUSE_NO_PAD_SUPPLY  = 5'h0f;
   localparam logic [4:0] CAUSE_PAD_ILIM       = 5'h10;
   localparam logic [4:0] CAUSE_GPIO           = 5'h11;
   localparam logic [4:0] CAUSE_HS_UART        = 5'h12;

   // Wake event vector positions, index 0 is highest priority
   localparam int unsigned NUM_WAKE     = 14;
   localparam int unsigned WK_RF_LEVEL  = 0;
   localparam int unsigned WK_TIMER     = 1;
   localparam int unsigned WK_AUX       = 2;
   localparam int unsigned WK_CARD      = 3;
   localparam int unsigned WK_I2C       = 4;
   localparam int unsigned WK_SPI       = 5;
   localparam int unsigned WK_USB       = 6;
   localparam int unsigned WK_TX_SUPPLY = 7;
   localparam int unsigned WK_THERM_A   = 8;
   localparam int unsigned WK_THERM_B   = 9;
   localparam int unsigned WK_NO_PAD    = 10;
   localparam int unsigned WK_PAD_ILIM  = 11;
   localparam int unsigned WK_GPIO      = 12;
   localparam int unsigned WK_HS_UART   = 13;

   // Reset value of the cause register
   localparam logic [4:0] CAUSE_RESET_VAL = CAUSE_POWER_ON;
endpackage

// file: rtl/rstgen_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser with agreement filter on stages two and three
module rstgen_sync
   import rstgen_pkg::*;
#(
   parameter int unsigned WIDTH = 1,
   parameter logic        INIT  = 1'b0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Asynchronous input and filtered level
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r;
   logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt, q_nxt;

   // Shift and accept a change only when stages two and three agree
   always_comb begin
      s1_nxt = din;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      q_nxt  = q_r;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            q_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= {WIDTH{INIT}};
         s2_r <= {WIDTH{INIT}};
         s3_r <= {WIDTH{INIT}};
         q_r  <= {WIDTH{INIT}};
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         q_r  <= q_nxt;
      end
   end

   assign dout = q_r;
endmodule
`default_nettype wire

// file: rtl/rstgen_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Six reset requesters combine into one global chip reset.
// - Unit software request resets all but this unit and debug.
// - Processor software request resets all but this unit and debug.
// - Host reset command resets partially; a control input can disable it.
// - Watchdog expiry resets all but this unit and debug.
// - Power-on resets everything, releasing once main and core supplies are good.
// - External low pin resets everything, this unit included.
// - Requesters are active-high levels; any enabled one asserts global reset.
// - Global reset holds while any requester stays high.
// - Reset stretched at least one cycle after last requester drops.
// - Power-on holds reset until internal supply-good rises.
// - On release registers are at reset values; fetch starts at zero.
// - Cause codes 0 to 5: power-on, RF, timer, aux, card, I2C.
// - Code 6 reserved; 7 SPI, 8 USB, 9 soft reset, 10 watchdog.
// - 11 tx supply, 12 host reset, 13 and 14 thermal falls.
// - 15 pad supply loss, 16 pad current limit, 17 GPIO, 18 UART.
module rstgen_top
   import rstgen_pkg::*;
(
   // Clock and unit reset (power-on or external pin only)
   input  wire logic          CLK,
   input  wire logic          RST_N,
   // Supply indications from the analog side and the external reset pin
   input  wire logic          MAIN_SUPPLY_OK,
   input  wire logic          CORE_SUPPLY_OK,
   input  wire logic          EXT_RESET_PIN_N,
   // Reset requesters on the system clock
   input  wire logic          SW_UNIT_REQ,
   input  wire logic          SW_CPU_REQ,
   input  wire logic          HOST_CMD_REQ,
   input  wire logic          HOST_CMD_EN,
   input  wire logic          WATCHDOG_REQ,
   // Wake events, one-cycle or level, on the system clock
   input  wire logic          WAKE_RF_LEVEL,
   input  wire logic          WAKE_TIMER,
   input  wire logic          WAKE_CONTACT_AUX,
   input  wire logic          WAKE_CARD_PRESENCE,
   input  wire logic          WAKE_I2C_MATCH,
   input  wire logic          WAKE_SPI,
   input  wire logic          WAKE_USB_RESUME,
   input  wire logic          WAKE_TX_SUPPLY,
   input  wire logic          WAKE_THERMAL_A,
   input  wire logic          WAKE_THERMAL_B,
   input  wire logic          WAKE_NO_PAD_SUPPLY,
   input  wire logic          WAKE_PAD_ILIM,
   input  wire logic          WAKE_GPIO,
   input  wire logic          WAKE_HS_UART,
   // Reset outputs
   output logic               GLOBAL_RESET,
   output logic               CHIP_RESET,
   output logic               UNIT_RESET,
   output logic [31:0]        BOOT_VECTOR,
   // Status
   output logic [CAUSE_W-1:0] WAKE_CAUSE_CODE,
   output logic [NUM_REQ-1:0] REQ_STATUS
);
   logic [2:0]         pin_sync;
   logic               main_ok_s, core_ok_s, ext_n_s;
   logic [NUM_REQ-1:0] req_vec;
   logic               any_req, any_partial, full_req;
   logic [1:0]         stretch_r, stretch_nxt;
   logic               glob_r, glob_nxt;
   logic               full_r, full_nxt;
   logic               unit_r, unit_nxt;
   logic [NUM_REQ-1:0] reqst_r, reqst_nxt;
   logic               prev_full_r, prev_full_nxt;
   logic [4:0]         cause_r, cause_nxt;
   logic [NUM_WAKE-1:0] wake_vec;
   logic               wake_any;
   logic [4:0]         wake_code;

   // Analog and pin levels come from outside the clock domain
   rstgen_sync #(.WIDTH(3), .INIT(1'b0)) u_sync (
      .clk   (CLK),
      .rst_n (RST_N),
      .din   ({MAIN_SUPPLY_OK, CORE_SUPPLY_OK, EXT_RESET_PIN_N}),
      .dout  (pin_sync)
   );
   assign main_ok_s = pin_sync[2];
   assign core_ok_s = pin_sync[1];
   assign ext_n_s   = pin_sync[0];

   // Level requesters, each active high
   assign req_vec[REQ_SW_UNIT]  = SW_UNIT_REQ;
   assign req_vec[REQ_SW_CPU]   = SW_CPU_REQ;
   assign req_vec[REQ_HOST_CMD] = HOST_CMD_REQ & HOST_CMD_EN;
   assign req_vec[REQ_WATCHDOG] = WATCHDOG_REQ;
   assign req_vec[REQ_POWER_ON] = ~(main_ok_s & core_ok_s);
   assign req_vec[REQ_EXT_PIN]  = ~ext_n_s;

   // Any requester asserts global reset; full scope for power and pin
   assign any_req     = |req_vec;
   assign full_req    = req_vec[REQ_POWER_ON] | req_vec[REQ_EXT_PIN];
   assign any_partial = req_vec[REQ_SW_UNIT] | req_vec[REQ_SW_CPU]
                      | req_vec[REQ_HOST_CMD] | req_vec[REQ_WATCHDOG];

   // Wake events in priority order
   assign wake_vec = {WAKE_HS_UART, WAKE_GPIO, WAKE_PAD_ILIM, WAKE_NO_PAD_SUPPLY,
                      WAKE_THERMAL_B, WAKE_THERMAL_A, WAKE_TX_SUPPLY, WAKE_USB_RESUME,
                      WAKE_SPI, WAKE_I2C_MATCH, WAKE_CARD_PRESENCE, WAKE_CONTACT_AUX,
                      WAKE_TIMER, WAKE_RF_LEVEL};
   assign wake_any = |wake_vec;

   // Lowest set index wins
   always_comb begin
      wake_code = CAUSE_RESERVED;
      for (int i = NUM_WAKE - 1; i >= 0; i--) begin
         if (wake_vec[i]) begin
            unique case (i)
               WK_RF_LEVEL:  wake_code = CAUSE_RF_LEVEL;
               WK_TIMER:     wake_code = CAUSE_WAKE_TIMER;
               WK_AUX:       wake_code = CAUSE_CONTACT_AUX;
               WK_CARD:      wake_code = CAUSE_CARD_PRESENCE;
               WK_I2C:       wake_code = CAUSE_I2C_MATCH;
               WK_SPI:       wake_code = CAUSE_SPI;
               WK_USB:       wake_code = CAUSE_USB_RESUME;
               WK_TX_SUPPLY: wake_code = CAUSE_TX_SUPPLY;
               WK_THERM_A:   wake_code = CAUSE_THERMAL_A;
               WK_THERM_B:   wake_code = CAUSE_THERMAL_B;
               WK_NO_PAD:    wake_code = CAUSE_NO_PAD_SUPPLY;
               WK_PAD_ILIM:  wake_code = CAUSE_PAD_ILIM;
               WK_GPIO:      wake_code = CAUSE_GPIO;
               WK_HS_UART:   wake_code = CAUSE_HS_UART;
               default:      wake_code = CAUSE_RESERVED;
            endcase
         end
      end
   end

   // Reset combiner with stretch; outputs change only on CLK edges
   always_comb begin
      stretch_nxt   = stretch_r;
      glob_nxt      = glob_r;
      full_nxt      = full_r;
      unit_nxt      = full_req;
      reqst_nxt     = req_vec;
      prev_full_nxt = full_req;
      if (any_req) begin
         stretch_nxt = STRETCH_LOAD;
         glob_nxt    = 1'b1;
         if (full_req) begin
            full_nxt = 1'b1;
         end
      end else if (stretch_r != 2'h0) begin
         stretch_nxt = stretch_r - 2'h1;
         glob_nxt    = 1'b1;
      end else begin
         glob_nxt = 1'b0;
         full_nxt = 1'b0;
      end
   end

   // Cause register: partial resets never clear it
   always_comb begin
      cause_nxt = cause_r;
      if (full_req && !prev_full_r) begin
         cause_nxt = CAUSE_POWER_ON;
      end else if (req_vec[REQ_HOST_CMD]) begin
         cause_nxt = CAUSE_HOST_RESET;
      end else if (req_vec[REQ_WATCHDOG] || req_vec[REQ_SW_CPU]) begin
         cause_nxt = CAUSE_WATCHDOG;
      end else if (req_vec[REQ_SW_UNIT]) begin
         cause_nxt = CAUSE_SOFT_RESET;
      end else if (wake_any && !glob_r) begin
         cause_nxt = wake_code;
      end
   end

   // Unit reset only from RST_N, which the pin and power-on drive outside
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         stretch_r   <= STRETCH_LOAD;
         glob_r      <= 1'b1;
         full_r      <= 1'b1;
         unit_r      <= 1'b1;
         reqst_r     <= '0;
         prev_full_r <= 1'b1;
         cause_r     <= CAUSE_RESET_VAL;
      end else begin
         stretch_r   <= stretch_nxt;
         glob_r      <= glob_nxt;
         full_r      <= full_nxt;
         unit_r      <= unit_nxt;
         reqst_r     <= reqst_nxt;
         prev_full_r <= prev_full_nxt;
         cause_r     <= cause_nxt;
      end
   end

   assign GLOBAL_RESET    = glob_r;
   assign CHIP_RESET      = full_r;
   assign UNIT_RESET      = unit_r;
   assign BOOT_VECTOR     = BOOT_ADDR;
   assign WAKE_CAUSE_CODE = cause_r;
   assign REQ_STATUS      = reqst_r;
endmodule
`default_nettype wire

// file: tb/rst_props.sv
`timescale 1ns/1ps
`default_nettype none
module rst_props
   import rstgen_pkg::*;
(
   // Clock and unit reset
   input wire logic               CLK,
   input wire logic               RST_N,
   // Supplies, pin and requesters
   input wire logic               MAIN_SUPPLY_OK,
   input wire logic               CORE_SUPPLY_OK,
   input wire logic               EXT_RESET_PIN_N,
   input wire logic               SW_UNIT_REQ,
   input wire logic               SW_CPU_REQ,
   input wire logic               HOST_CMD_REQ,
   input wire logic               HOST_CMD_EN,
   input wire logic               WATCHDOG_REQ,
   // Outputs under watch
   input wire logic               GLOBAL_RESET,
   input wire logic               CHIP_RESET,
   input wire logic               UNIT_RESET,
   input wire logic [31:0]        BOOT_VECTOR,
   input wire logic [CAUSE_W-1:0] WAKE_CAUSE_CODE,
   input wire logic [NUM_REQ-1:0] REQ_STATUS
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Nothing that may move the cause code; full-scope path must be idle
   logic quiet;
   logic host;
   assign host = HOST_CMD_REQ && HOST_CMD_EN;
   assign quiet = !(SW_UNIT_REQ || SW_CPU_REQ || HOST_CMD_REQ || WATCHDOG_REQ)
                  && MAIN_SUPPLY_OK && CORE_SUPPLY_OK && EXT_RESET_PIN_N && !UNIT_RESET;

   hold_any_a: assert property (|REQ_STATUS |-> GLOBAL_RESET)
      else $error("reset low with a request");
   stretch_a: assert property ($past(RST_N) && $past(|REQ_STATUS) |-> GLOBAL_RESET)
      else $error("no stretch cycle");
   release_a: assert property ($past(RST_N, 2) && REQ_STATUS == '0 && $past(REQ_STATUS) == '0
      |-> !GLOBAL_RESET) else $error("reset held too long");
   host_gate_a: assert property (!HOST_CMD_EN |=> !REQ_STATUS[REQ_HOST_CMD])
      else $error("host reset not gated");
   host_take_a: assert property (host && !UNIT_RESET |=> REQ_STATUS[REQ_HOST_CMD]
      && WAKE_CAUSE_CODE == CAUSE_HOST_RESET) else $error("host reset missed");
   wdog_cause_a: assert property ((WATCHDOG_REQ || SW_CPU_REQ) && !host && !UNIT_RESET
      |=> WAKE_CAUSE_CODE == CAUSE_WATCHDOG) else $error("bad cause 10");
   unit_cause_a: assert property (SW_UNIT_REQ && !WATCHDOG_REQ && !SW_CPU_REQ && !host
      && !UNIT_RESET |=> WAKE_CAUSE_CODE == CAUSE_SOFT_RESET) else $error("bad cause 9");
   cause_keep_a: assert property (GLOBAL_RESET && quiet |=> $stable(WAKE_CAUSE_CODE))
      else $error("cause moved");
   full_scope_a: assert property (UNIT_RESET |-> CHIP_RESET && GLOBAL_RESET)
      else $error("full scope not global");
   pin_a: assert property (!EXT_RESET_PIN_N [*8] |-> UNIT_RESET)
      else $error("pin ignored");
   supply_a: assert property (!CORE_SUPPLY_OK [*8] |-> UNIT_RESET && GLOBAL_RESET)
      else $error("supply low ignored");
   boot_vec_a: assert property (BOOT_VECTOR == BOOT_ADDR)
      else $error("start address not zero");
endmodule
`default_nettype wire

// file: tb/req_model.sv
`timescale 1ns/1ps
`default_nettype none
// Requesters outside the unit: software, host, watchdog and the pin driver
module req_model (
   // Clock and command from the bench
   input  wire logic       clk,
   input  wire logic [4:0] want,
   // Request levels
   output logic            sw_unit,
   output logic            sw_cpu,
   output logic            host_req,
   output logic            wdog,
   output logic            pin_n
);
   // Levels change on the falling edge only, held until told otherwise
   always_ff @(negedge clk) begin
      sw_unit  <= want[0];
      sw_cpu   <= want[1];
      host_req <= want[2];
      wdog     <= want[3];
      pin_n    <= !want[4]; // Pin is pulled low to request
   end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] %0t value mismatch", $time); end end
module tb_top;
   import rstgen_pkg::*;
   logic        clk, rst_n, main_ok, core_ok, host_en;
   logic [4:0]  want;
   logic [13:0] wk;
   wire logic   sw_unit, sw_cpu, host_req, wdog, pin_n;
   logic        gr, chip_r, unit_r;
   logic [31:0] bvec;
   logic [4:0]  cause;
   logic [5:0]  rstat;
   int          bad_count, checks_done;
   logic [4:0]  pcode [4] = '{5'h09, 5'h0a, 5'h0c, 5'h0a};
   logic [4:0]  wcode [14] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08,
                              5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12};

   req_model pm (.clk(clk), .want(want), .sw_unit(sw_unit), .sw_cpu(sw_cpu),
      .host_req(host_req), .wdog(wdog), .pin_n(pin_n));
   rstgen_top dut (.CLK(clk), .RST_N(rst_n), .MAIN_SUPPLY_OK(main_ok),
      .CORE_SUPPLY_OK(core_ok), .EXT_RESET_PIN_N(pin_n), .SW_UNIT_REQ(sw_unit),
      .SW_CPU_REQ(sw_cpu), .HOST_CMD_REQ(host_req), .HOST_CMD_EN(host_en),
      .WATCHDOG_REQ(wdog), .WAKE_RF_LEVEL(wk[0]), .WAKE_TIMER(wk[1]),
      .WAKE_CONTACT_AUX(wk[2]), .WAKE_CARD_PRESENCE(wk[3]), .WAKE_I2C_MATCH(wk[4]),
      .WAKE_SPI(wk[5]), .WAKE_USB_RESUME(wk[6]), .WAKE_TX_SUPPLY(wk[7]),
      .WAKE_THERMAL_A(wk[8]), .WAKE_THERMAL_B(wk[9]), .WAKE_NO_PAD_SUPPLY(wk[10]),
      .WAKE_PAD_ILIM(wk[11]), .WAKE_GPIO(wk[12]), .WAKE_HS_UART(wk[13]),
      .GLOBAL_RESET(gr), .CHIP_RESET(chip_r), .UNIT_RESET(unit_r), .BOOT_VECTOR(bvec),
      .WAKE_CAUSE_CODE(cause), .REQ_STATUS(rstat));

   // 200 MHz system clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task finish_test;
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Command goes out after a rising edge so the model never races the bench
   task req(input logic [4:0] v);
      @(posedge clk);
      want = v;
      @(negedge clk);
   endtask
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait for release of global reset
   task wait_low;
      int i;
      i = 0;
      while (gr !== 1'b0 && i < 40) begin
         @(negedge clk);
         i++;
      end
      if (gr !== 1'b0) begin
         bad_count++;
         $display("[ERR] %0t reset never released", $time);
         finish_test;
      end
   endtask

   initial begin
      {rst_n, host_en, want, wk, bad_count, checks_done} = '0;
      {main_ok, core_ok} = 2'b11;
      host_en = 1'b1;
      tick(20);
      rst_n = 1'b1;
      wait_low;
      `CHK(cause, 5'h00)
      `CHK(chip_r, 1'b0)
      `CHK(bvec, 32'h0000_0000)
      // Each partial requester held four cycles, then the stretch
      for (int i = 0; i < 4; i++) begin
         req(5'h01 << i);
         tick(1);
         `CHK(gr, 1'b1)
         `CHK(unit_r, 1'b0)
         `CHK(chip_r, 1'b0)
         `CHK(rstat, 6'h01 << i)
         `CHK(cause, pcode[i])
         tick(2);
         `CHK(gr, 1'b1)
         req(5'h00);
         tick(1);
         `CHK(gr, 1'b1)
         tick(1);
         `CHK(gr, 1'b0)
      end
      // Host command with the enable off is ignored
      host_en = 1'b0;
      req(5'h04);
      tick(2);
      `CHK(gr, 1'b0)
      `CHK(rstat, 6'h00)
      req(5'h00);
      host_en = 1'b1;
      // Overlapping levels keep reset up without a gap
      req(5'h08);
      req(5'h09);
      req(5'h01);
      tick(1);
      `CHK(gr, 1'b1)
      req(5'h00);
      wait_low;
      // Every wake source, one cycle each
      for (int i = 0; i < 14; i++) begin
         wk = 14'h0001 << i;
         @(negedge clk);
         wk = '0;
         `CHK(cause, wcode[i])
      end
      tick(5);
      `CHK(cause, 5'h12)
      // Wake during a partial reset must not overwrite the soft cause
      req(5'h01);
      wk = 14'h0001;
      @(negedge clk);
      wk = '0;
      tick(1);
      `CHK(cause, 5'h09)
      req(5'h00);
      wait_low;
      // Pin low resets the unit scope too
      req(5'h10);
      tick(8);
      `CHK(unit_r, 1'b1)
      `CHK(chip_r, 1'b1)
      req(5'h00);
      wait_low;
      `CHK(cause, 5'h00)
      // Supply drops hold the whole chip
      core_ok = 1'b0;
      tick(8);
      `CHK(gr, 1'b1)
      core_ok = 1'b1;
      wait_low;
      main_ok = 1'b0;
      tick(8);
      `CHK(unit_r, 1'b1)
      main_ok = 1'b1;
      wait_low;
      // Second unit reset in mid-run
      rst_n = 1'b0;
      tick(3);
      `CHK(gr, 1'b1)
      `CHK(rstat, 6'h00)
      rst_n = 1'b1;
      wait_low;
      `CHK(cause, 5'h00)
      finish_test;
   end
endmodule
bind rstgen_top rst_props u_props (.*);
`default_nettype wire
